//--- logic/prd_engine.sv
/*
 * Device-side packed descriptor ring engine: polls, fetches and offers
 * descriptors, writes used descriptors, reads driver suppression.
 * Assumes a 64-bit memory port with one outstanding read and a user that
 * consumes buffers and reports completion.
 */
`timescale 1ns/1ns
`default_nettype none
`include "prd_consts.svh"
// Overview of operation
// - in-order mode may report a batch by one used entry with final id.
// - used entry lands on batch's first slot; device advances by batch size.
// - first descriptor of a request marked used only after all the rest.
// - control field: 0 enable, 1 disable, 2 per-descriptor, 3 reserved.
// - per-descriptor mode fires only at matching offset and wrap; with evidx clear the code notifies on every used write instead.
// - after writing used entries, read driver suppression to decide notify.
// - start descriptors in ring order, used writes in completion order.
// - descriptor is 64-bit address, 32-bit length, 16-bit id, 16-bit flags.
// - ring starts zeroed, so all flags initially clear.
// - suppression is offset15+wrap1, then control2 plus 14 zero bits.
// - never write a device-readable buffer; avoid reading writable ones.
// - consume a descriptor only after its available bit changes.
// - after changing the used bit, never touch that descriptor again.
// - list length bounded by device limit and queue size.
// - consume chained descriptors in posted order.
// - wrap counters start at one, flip after the last slot.
// - used marking sets used bit 15 and available bit 7 to own wrap.
// - flag value 2 marks a buffer device-writable.
module prd_engine #(
    parameter logic [15:0] MAX_CHAIN = `PRD_MAX_CHAIN // device list limit
) (
    input  wire logic                 clk,           // 100 MHz clock
    input  wire logic                 srst,          // sync reset, high
    input  wire prd_pkg::prd_reg_req_t reg_req,      // register strobes
    output logic [31:0]               reg_rdata,     // read data, next cycle
    output logic                      mem_req_valid, // memory request
    input  wire logic                 mem_req_ready, // memory accepts
    output prd_pkg::prd_mem_req_t     mem_req,       // address, data, we
    input  wire logic                 mem_rvalid,    // read data valid
    input  wire logic [63:0]          mem_rdata,     // read data word
    output logic                      buf_valid,     // buffer offered
    input  wire logic                 buf_ready,     // user takes buffer
    output prd_pkg::prd_buf_t         buf_out,       // buffer element
    input  wire logic                 cmpl_valid,    // request done
    output logic                      cmpl_ready,    // completion taken
    input  wire prd_pkg::prd_cmpl_t   cmpl,          // written length, flush
    output logic                      used_notify    // notify pulse
);
    import prd_pkg::*;

    prd_eng_state_t s;
    prd_eng_state_t next_s;
    prd_ptr_t       av;
    prd_ptr_t       us;
    prd_desc_hi_t   rd_hi;
    prd_evt_t       evt;
    logic           avail_ok;
    logic           av_adv;
    logic           us_adv;
    logic           gate_notify;
    logic [15:0]    limit;
    logic [63:0]    av_slot;
    logic [63:0]    us_slot;

    assign rd_hi    = mem_rdata;
    // 4-byte structure inside an 8-byte aligned word
    assign evt      = s.evt_base[2] ? mem_rdata[63:32] : mem_rdata[31:0];
    // zeroed ring never looks available against wrap 1
    assign avail_ok = rd_hi.flags[`PRD_F_AVAIL] == av.wrap && rd_hi.flags[`PRD_F_USED] != av.wrap;
    assign limit    = (s.qsize < MAX_CHAIN) ? s.qsize : MAX_CHAIN;
    assign av_slot  = s.ring_base + {45'h0, av.idx, 4'h0} + `PRD_HI_OFF;
    assign us_slot  = s.ring_base + {45'h0, us.idx, 4'h0} + `PRD_HI_OFF;
    assign av_adv   = s.st == S_OFFER && buf_ready;
    assign us_adv   = s.st == S_W_EVT && mem_rvalid;

    prd_ring_ptr u_avail_ptr (
        .clk   (clk),
        .srst  (srst),
        .clr   (~s.en),
        .adv   (av_adv),
        .step  (16'h0001),
        .qsize (s.qsize),
        .ptr   (av)
    );

    prd_ring_ptr u_used_ptr (
        .clk   (clk),
        .srst  (srst),
        .clr   (~s.en),
        .adv   (us_adv),
        .step  (s.batch_cnt), // skip the whole batch at once
        .qsize (s.qsize),
        .ptr   (us)
    );

    prd_evt_gate u_evt_gate (
        .evt    (evt),
        .evidx  (s.evidx),
        .slot   (us.idx),
        .wrap   (us.wrap),
        .notify (gate_notify)
    );

    always_comb begin
        next_s        = s;
        next_s.rdata  = 32'h0000_0000;
        next_s.notify = 1'b0;
        // register port
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                `PRD_REG_CTRL: begin
                    next_s.en    = reg_req.wdata[`PRD_CTRL_EN];
                    next_s.inord = reg_req.wdata[`PRD_CTRL_INORD];
                    next_s.evidx = reg_req.wdata[`PRD_CTRL_EVIDX];
                end
                `PRD_REG_RING_LO: next_s.ring_base[31:0]  = {reg_req.wdata[31:4], 4'h0};
                `PRD_REG_RING_HI: next_s.ring_base[63:32] = reg_req.wdata;
                `PRD_REG_EVT_LO:  next_s.evt_base[31:0]   = {reg_req.wdata[31:2], 2'h0};
                `PRD_REG_EVT_HI:  next_s.evt_base[63:32]  = reg_req.wdata;
                `PRD_REG_QSIZE:   next_s.qsize = {1'b0, reg_req.wdata[14:0]};
                `PRD_REG_ERR:     next_s.err_long = s.err_long & ~reg_req.wdata[0];
                default: ;
            endcase
        end
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                `PRD_REG_CTRL:    next_s.rdata = {29'h0, s.evidx, s.inord, s.en};
                `PRD_REG_RING_LO: next_s.rdata = s.ring_base[31:0];
                `PRD_REG_RING_HI: next_s.rdata = s.ring_base[63:32];
                `PRD_REG_EVT_LO:  next_s.rdata = s.evt_base[31:0];
                `PRD_REG_EVT_HI:  next_s.rdata = s.evt_base[63:32];
                `PRD_REG_QSIZE:   next_s.rdata = {16'h0, s.qsize};
                `PRD_REG_STATUS:  next_s.rdata = {us.wrap, us.idx, av.wrap, av.idx};
                `PRD_REG_ERR:     next_s.rdata = {31'h0, s.err_long};
                default:          next_s.rdata = 32'h0000_0000;
            endcase
        end
        // controller
        unique case (s.st)
            S_IDLE: begin
                if (s.en && s.qsize != 16'h0000) begin
                    next_s.st = S_RD_FLAGS;
                end
            end
            S_RD_FLAGS: if (mem_req_ready) next_s.st = S_W_FLAGS; // flags word first
            S_W_FLAGS: begin
                if (mem_rvalid) begin
                    if (avail_ok) begin
                        next_s.st = S_RD_HI;
                    end else if (s.chain_cnt != 16'h0000) begin
                        next_s.st = S_RD_FLAGS; // rest of a list is posted first
                    end else if (s.batch_cnt != 16'h0000) begin
                        next_s.st = S_WR_USED; // nothing more to join, close batch
                    end else begin
                        next_s.st = S_IDLE;
                    end
                end
            end
            S_RD_HI: if (mem_req_ready) next_s.st = S_W_HI;
            S_W_HI: begin
                if (mem_rvalid) begin
                    next_s.hi = rd_hi; // fresh copy after availability seen
                    next_s.st = S_RD_LO;
                end
            end
            S_RD_LO: if (mem_req_ready) next_s.st = S_W_LO;
            S_W_LO: begin
                if (mem_rvalid) begin
                    next_s.baddr = mem_rdata;
                    if (s.hi.flags[`PRD_F_CHAIN] && s.chain_cnt + 16'h0001 >= limit) begin
                        next_s.err_long = 1'b1; // list would outgrow the limit
                        next_s.st       = S_HALT;
                    end else begin
                        next_s.st = S_OFFER;
                    end
                end
            end
            S_OFFER: begin
                if (buf_ready) begin
                    next_s.chain_cnt = s.chain_cnt + 16'h0001;
                    next_s.batch_cnt = s.batch_cnt + 16'h0001;
                    next_s.batch_wr  = s.batch_wr | s.hi.flags[`PRD_F_WRITE];
                    if (s.hi.flags[`PRD_F_CHAIN]) begin
                        next_s.st = S_RD_FLAGS; // next link is the next slot
                    end else begin
                        next_s.batch_id  = s.hi.id; // id rides on the last link
                        next_s.chain_cnt = 16'h0000;
                        next_s.st        = S_WAIT_CMPL;
                    end
                end
            end
            S_WAIT_CMPL: begin
                if (cmpl_valid) begin
                    // no length reported into a read-only list
                    next_s.batch_len = s.batch_wr ? cmpl.len : 32'h0000_0000;
                    next_s.st        = (s.inord && !cmpl.flush) ? S_RD_FLAGS : S_WR_USED;
                end
            end
            S_WR_USED: if (mem_req_ready) next_s.st = S_RD_EVT;
            S_RD_EVT:  if (mem_req_ready) next_s.st = S_W_EVT;
            S_W_EVT: begin
                if (mem_rvalid) begin
                    next_s.notify    = gate_notify;
                    next_s.batch_cnt = 16'h0000;
                    next_s.batch_wr  = 1'b0;
                    next_s.st        = S_IDLE;
                end
            end
            S_HALT: if (!s.en) next_s.st = S_IDLE;
            default: next_s.st = S_IDLE;
        endcase
        if (reg_req.wr && reg_req.addr == `PRD_REG_ERR && s.st == S_W_LO && mem_rvalid
            && s.hi.flags[`PRD_F_CHAIN] && s.chain_cnt + 16'h0001 >= limit) begin
            next_s.err_long = 1'b1; // a new error outlives a same-cycle clear
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s       <= '0;
            s.st    <= S_IDLE;
            s.qsize <= `PRD_QSIZE_RST;
        end else begin
            s <= next_s;
        end
    end

    always_comb begin
        mem_req_valid = 1'b0;
        mem_req       = '{we: 1'b0, addr: av_slot, wdata: 64'h0};
        unique case (s.st)
            S_RD_FLAGS, S_RD_HI: mem_req_valid = 1'b1;
            S_RD_LO: begin
                mem_req_valid = 1'b1;
                mem_req.addr  = av_slot - `PRD_HI_OFF;
            end
            S_WR_USED: begin
                mem_req_valid = 1'b1;
                mem_req.we    = 1'b1;
                mem_req.addr  = us_slot; // over the batch's first slot
                // flags, id and length leave in one write, the used bit with them
                mem_req.wdata = {us.wrap, 7'h00, us.wrap, 5'h00, s.batch_wr, 1'b0,
                                 s.batch_id, s.batch_len};
            end
            S_RD_EVT: begin
                mem_req_valid = 1'b1;
                mem_req.addr  = {s.evt_base[63:3], 3'h0};
            end
            default: ;
        endcase
    end

    assign buf_valid   = s.st == S_OFFER;
    assign buf_out     = '{addr: s.baddr, len: s.hi.len, id: s.hi.id,
                           writable: s.hi.flags[`PRD_F_WRITE], last: ~s.hi.flags[`PRD_F_CHAIN]};
    assign cmpl_ready  = s.st == S_WAIT_CMPL;
    assign used_notify = s.notify;
    assign reg_rdata   = s.rdata;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_avail_gate: assert property (s.st == S_W_FLAGS && mem_rvalid |=> (s.st == S_RD_HI) == $past(avail_ok))
        else $error("descriptor fetched without a changed available bit");
    a_flags_first: assert property ($rose(s.st == S_RD_HI) |-> $past(s.st == S_W_FLAGS && avail_ok))
        else $error("body read before flags confirmed");
    a_used_bits: assert property (mem_req_valid && mem_req.we |->
        mem_req.wdata[48 + `PRD_F_USED] == us.wrap && mem_req.wdata[48 + `PRD_F_AVAIL] == us.wrap)
        else $error("used marking bits do not match wrap counter");
    // batch spans from the used position up to the next slot still to fetch
    a_used_head: assert property (mem_req_valid && mem_req.we |-> mem_req.addr == us_slot &&
        17'(us.idx) + 17'(s.batch_cnt) == (us.wrap == av.wrap ? 17'(av.idx) : 17'(av.idx) + 17'(s.qsize)))
        else $error("used entry not at batch head");
    a_ro_no_len: assert property (mem_req_valid && mem_req.we && !s.batch_wr |->
        mem_req.wdata[31:0] == 32'h0 && !mem_req.wdata[48 + `PRD_F_WRITE])
        else $error("written length reported for read-only buffers");
    a_whole_req: assert property (mem_req_valid && mem_req.we |-> s.chain_cnt == 16'h0 && s.batch_cnt != 16'h0)
        else $error("used entry written mid-request");
    a_single_write: assert property (mem_req_valid && mem_req.we && mem_req_ready |=>
        !(mem_req_valid && mem_req.we) [*3])
        else $error("descriptor modified after used marking");
    a_evt_after: assert property (mem_req_valid && mem_req.we && mem_req_ready |=>
        s.st == S_RD_EVT ##[1:300] s.st == S_W_EVT)
        else $error("suppression not read after used write");
    a_ring_order: assert property (av.idx != $past(av.idx) && s.en && $past(s.en) |-> $past(av_adv))
        else $error("ring position moved without consuming");
    a_batch_hold: assert property (s.st == S_WAIT_CMPL && cmpl_valid && s.inord && !cmpl.flush |=>
        s.st == S_RD_FLAGS && s.batch_cnt == $past(s.batch_cnt))
        else $error("in-order batch not extended");
    a_chain_limit: assert property (buf_valid |-> s.chain_cnt < limit)
        else $error("list longer than limit offered");
    a_notify_src: assert property (used_notify |-> $past(s.st == S_W_EVT && mem_rvalid && gate_notify))
        else $error("notification without suppression check");

    c_batch: cover property (mem_req_valid && mem_req.we && s.inord && s.batch_cnt > 16'h0001);
    c_notify: cover property (used_notify);
    c_chain: cover property (buf_valid && buf_ready && !buf_out.last);
    c_halt: cover property (s.st == S_HALT);
endmodule : prd_engine
`default_nettype wire

//--- common/prd_consts.svh
/*
 * Constants of the packed ring engine: descriptor flag positions, event modes,
 * register offsets, control bits and reset values.
 * Assumes inclusion by bare name from the design modules and the bench.
 */
`ifndef PRD_CONSTS_SVH
`define PRD_CONSTS_SVH

// descriptor flag word bit positions
`define PRD_F_CHAIN      0
`define PRD_F_WRITE      1
`define PRD_F_AVAIL      7
`define PRD_F_USED       15
// byte offset of the len/id/flags half inside a 16-byte slot
`define PRD_HI_OFF       64'h0000_0000_0000_0008
// notification control modes
`define PRD_EVT_ENABLE   2'h0
`define PRD_EVT_DISABLE  2'h1
`define PRD_EVT_DESC     2'h2
// register byte offsets
`define PRD_REG_CTRL     8'h00
`define PRD_REG_RING_LO  8'h04
`define PRD_REG_RING_HI  8'h08
`define PRD_REG_EVT_LO   8'h0C
`define PRD_REG_EVT_HI   8'h10
`define PRD_REG_QSIZE    8'h14
`define PRD_REG_STATUS   8'h18
`define PRD_REG_ERR      8'h1C
// control register bits
`define PRD_CTRL_EN      0
`define PRD_CTRL_INORD   1
`define PRD_CTRL_EVIDX   2
// reset values and default list limit
`define PRD_QSIZE_RST    16'h0000
`define PRD_WRAP_RST     1'b1
`define PRD_MAX_CHAIN    16'h0100

`endif

//--- common/prd_pkg.sv
/*
 * Types of the packed ring engine: memory words, user-side carriers,
 * register port and controller state.
 * Assumes prd_consts.svh on the include path.
 */
package prd_pkg;
    // upper 8 bytes of a descriptor as one little-endian 64-bit word
    typedef struct packed {
        logic [15:0] flags;
        logic [15:0] id;
        logic [31:0] len;
    } prd_desc_hi_t;

    // suppression structure as one little-endian 32-bit word
    typedef struct packed {
        logic [13:0] rsvd;
        logic [1:0]  mode;
        logic        wrap;
        logic [14:0] off;
    } prd_evt_t;

    typedef struct packed {
        logic        we;
        logic [63:0] addr;
        logic [63:0] wdata;
    } prd_mem_req_t;

    typedef struct packed {
        logic [63:0] addr;
        logic [31:0] len;
        logic [15:0] id;
        logic        writable;
        logic        last;
    } prd_buf_t;

    typedef struct packed {
        logic [31:0] len;
        logic        flush;
    } prd_cmpl_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } prd_reg_req_t;

    typedef struct packed {
        logic        wrap;
        logic [14:0] idx;
    } prd_ptr_t;

    typedef enum logic [3:0] {
        S_IDLE, S_RD_FLAGS, S_W_FLAGS, S_RD_HI, S_W_HI, S_RD_LO, S_W_LO,
        S_OFFER, S_WAIT_CMPL, S_WR_USED, S_RD_EVT, S_W_EVT, S_HALT
    } prd_state_t;

    typedef struct packed {
        prd_state_t   st;
        logic         en;
        logic         inord;
        logic         evidx;
        logic [63:0]  ring_base;
        logic [63:0]  evt_base;
        logic [15:0]  qsize;
        logic         err_long;
        logic [31:0]  rdata;
        prd_desc_hi_t hi;
        logic [63:0]  baddr;
        logic [15:0]  chain_cnt;
        logic [15:0]  batch_cnt;
        logic [15:0]  batch_id;
        logic         batch_wr;
        logic [31:0]  batch_len;
        logic         notify;
    } prd_eng_state_t;
endpackage : prd_pkg

//--- logic/prd_ring_ptr.sv
/*
 * Ring position with wrap counter, advanced by a step of slots.
 * Assumes step never exceeds qsize and qsize is nonzero while adv is high.
 */
`timescale 1ns/1ns
`default_nettype none
`include "prd_consts.svh"
module prd_ring_ptr (
    input  wire logic            clk,   // device clock
    input  wire logic            srst,  // sync reset, high
    input  wire logic            clr,   // reinit to slot 0, wrap 1
    input  wire logic            adv,   // advance by step
    input  wire logic [15:0]     step,  // slots to skip
    input  wire logic [15:0]     qsize, // ring length in slots
    output prd_pkg::prd_ptr_t    ptr    // current slot and wrap
);
    import prd_pkg::*;
    prd_ptr_t    s;
    prd_ptr_t    next_s;
    logic [16:0] sum;

    always_comb begin
        next_s = s;
        sum    = {2'h0, s.idx} + {1'b0, step};
        if (clr) begin
            next_s = '{wrap: `PRD_WRAP_RST, idx: 15'h0000};
        end else if (adv) begin
            if (sum >= {1'b0, qsize}) begin
                next_s.idx  = 15'(sum - {1'b0, qsize});
                next_s.wrap = ~s.wrap; // flips when passing the last slot
            end else begin
                next_s.idx = sum[14:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '{wrap: `PRD_WRAP_RST, idx: 15'h0000};
        end else begin
            s <= next_s;
        end
    end

    assign ptr = s;
endmodule : prd_ring_ptr
`default_nettype wire

//--- logic/prd_evt_gate.sv
/*
 * Used-buffer notification decision from the driver's suppression word.
 * Assumes slot and wrap name the descriptor just marked used.
 */
`timescale 1ns/1ns
`default_nettype none
`include "prd_consts.svh"
module prd_evt_gate (
    input  wire prd_pkg::prd_evt_t evt,    // driver suppression structure
    input  wire logic              evidx,  // event index feature on
    input  wire logic [14:0]       slot,   // slot written used
    input  wire logic              wrap,   // wrap counter of that slot
    output logic                   notify  // send a notification
);
    import prd_pkg::*;
    always_comb begin
        unique case (evt.mode)
            `PRD_EVT_ENABLE:  notify = 1'b1;
            `PRD_EVT_DISABLE: notify = 1'b0;
            // without the feature the mode is illegal; fall back to enabled
            `PRD_EVT_DESC:    notify = evidx ? (slot == evt.off && wrap == evt.wrap) : 1'b1;
            default:          notify = 1'b0; // reserved code, stay quiet
        endcase
    end
endmodule : prd_evt_gate
`default_nettype wire

//--- verif/prd_drv_mem.sv
/* Driver-side memory for the ring engine: ring and suppression word.
   Assumes the bench posts descriptors by writing mem directly. */
`timescale 1ns/1ns
`default_nettype none
module prd_drv_mem (
    input  wire logic                  clk,           // device clock
    input  wire logic                  srst,          // sync reset, high
    input  wire logic                  mem_req_valid, // engine request
    output logic                       mem_req_ready, // accept, random stalls
    input  wire prd_pkg::prd_mem_req_t mem_req,       // address, data, we
    output logic                       mem_rvalid,    // read answer
    output logic [63:0]                mem_rdata      // answer word
);
    import prd_pkg::*;
    logic [63:0] mem [0:127];
    logic        pend = 1'b0;
    logic [63:0] pdata;
    int          dly;
    initial begin
        mem_rdata = 64'h0;
        mem_req_ready = 1'b0;
        mem_rvalid = 1'b0;
        for (int i = 0; i < 128; i++) mem[i] = 64'h0;
    end
    always @(posedge clk) begin
        mem_rvalid <= 1'b0;
        mem_rdata <= ~mem_rdata; // between answers the old word flips every cycle
        mem_req_ready <= ($urandom_range(0, 3) != 0) && !pend;
        if (srst) begin
            pend <= 1'b0;
        end else if (pend) begin
            if (dly == 0) begin
                mem_rvalid <= 1'b1;
                mem_rdata <= pdata;
                pend <= 1'b0;
            end
            dly <= dly - 1;
        end else if (mem_req_valid && mem_req_ready) begin
            if (mem_req.we) mem[mem_req.addr[9:3]] <= mem_req.wdata;
            else begin
                pend <= 1'b1;
                pdata <= mem[mem_req.addr[9:3]];
                dly <= $urandom_range(0, 4);
            end
        end
    end
endmodule : prd_drv_mem
`default_nettype wire

//--- verif/tb_packed_ring_descriptor_engine.sv
/* Bench: posts lists, checks offers, used entries and notifications.
   Assumes prd_drv_mem, ring at 0x0, suppression word at 0x200. */
`timescale 1ns/1ns
`default_nettype none
`include "prd_consts.svh"
module tb_packed_ring_descriptor_engine;
    import prd_pkg::*;
    logic         clk = 1'b0;
    logic         srst = 1'b1;
    logic         buf_ready = 1'b0;
    logic         cmpl_valid = 1'b0;
    prd_cmpl_t    cmpl = '0;
    prd_reg_req_t reg_req = '0;
    logic         mem_req_valid, mem_req_ready, mem_rvalid, buf_valid, cmpl_ready, used_notify;
    logic [31:0]  reg_rdata;
    logic [63:0]  mem_rdata;
    prd_mem_req_t mem_req;
    prd_buf_t     buf_out;
    int           fail_count = 0;
    int           tests_run = 0;
    int           notes = 0;
    always #5 clk = ~clk;
    always @(posedge clk) if (used_notify === 1'b1) notes++;
    prd_engine u_dut (.*);
    prd_drv_mem u_mem (.*);
    task automatic check(input string what, input logic [127:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // used entry as the driver expects it back
    function automatic logic [63:0] used_word(input logic w, wr, input logic [15:0] id, input logic [31:0] len);
        return {w, 7'h0, w, 5'h0, wr, 1'b0, id, wr ? len : 32'h0};
    endfunction : used_word
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        reg_req <= '0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_req <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk);
        reg_req <= '0;
        #1 d = reg_rdata;
        @(posedge clk);
    endtask : rd
    // one list of n slots from slot s; en is the expected notify count
    task automatic serve(input int s, n, input logic w, wl, input logic [15:0] id,
                         input prd_evt_t ev, input int en);
        logic [63:0] a [2];
        logic [31:0] l [2];
        logic [31:0] cl;
        int          k, t, n0;
        u_mem.mem[64] = {32'h0, ev};
        cl = $urandom;
        n0 = notes;
        for (k = n - 1; k >= 0; k--) begin // head made available last
            a[k] = {$urandom, $urandom};
            l[k] = $urandom;
            u_mem.mem[2*(s+k)] = a[k];
            u_mem.mem[2*(s+k)+1] = {!w, 7'h0, w, 5'h0, wl && k == n - 1, k != n - 1, id, l[k]};
        end
        for (k = 0; k < n; k++) begin
            t = 0;
            do begin @(posedge clk); t++; end while (buf_valid !== 1'b1 && t < 300);
            check("buf_out", buf_out, {a[k], l[k], id, wl && k == n - 1, k == n - 1});
            buf_ready <= 1'b1;
            @(posedge clk);
            buf_ready <= 1'b0;
        end
        cmpl <= '{cl, 1'b1};
        cmpl_valid <= 1'b1;
        t = 0;
        do begin @(posedge clk); t++; end while (cmpl_ready !== 1'b1 && t < 300);
        cmpl_valid <= 1'b0;
        repeat (80) @(posedge clk);
        check("used", u_mem.mem[2*s+1], used_word(w, wl, id, cl));
        if (n > 1) check("tail", u_mem.mem[2*s+3], {!w, 7'h0, w, 5'h0, wl, 1'b0, id, l[1]});
        check("notify", 128'(notes - n0), 128'(en));
    endtask : serve
    // in-order batch of two one-slot lists across the ring end, slots 3 then 0
    task automatic batch2(input logic [15:0] ida, idb);
        logic [31:0] cl;
        int          k, t, n0;
        u_mem.mem[64] = {32'h0, 14'h0, `PRD_EVT_ENABLE, 16'h0};
        u_mem.mem[1] = {1'b0, 7'h0, 1'b1, 5'h0, 2'h2, idb, 32'h40}; // driver wrap now 1
        u_mem.mem[7] = {1'b1, 7'h0, 1'b0, 5'h0, 2'h0, ida, 32'h20};
        cl = $urandom;
        n0 = notes;
        for (k = 0; k < 2; k++) begin
            t = 0;
            do begin @(posedge clk); t++; end while (buf_valid !== 1'b1 && t < 300);
            check("batch_id", buf_out.id, k ? idb : ida);
            buf_ready <= 1'b1;
            @(posedge clk);
            buf_ready <= 1'b0;
            cmpl <= '{cl, 1'b0};
            cmpl_valid <= 1'b1;
            t = 0;
            do begin @(posedge clk); t++; end while (cmpl_ready !== 1'b1 && t < 300);
            cmpl_valid <= 1'b0;
        end
        repeat (80) @(posedge clk);
        check("batch_used", u_mem.mem[7], used_word(1'b0, 1'b1, idb, cl));
        check("skipped", u_mem.mem[1][63:32], {1'b0, 7'h0, 1'b1, 5'h0, 2'h2, idb});
        check("batch_notify", 128'(notes - n0), 128'd1);
    endtask : batch2
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        logic [31:0] d;
        void'($urandom(32'haf02));
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(`PRD_REG_STATUS, d);
        check("status", d, 32'h8000_8000);
        rd(8'h20, d);
        check("unmapped", d, 32'h0);
        wr(`PRD_REG_EVT_LO, 32'h200);
        wr(`PRD_REG_QSIZE, 32'h4);
        wr(`PRD_REG_CTRL, 32'h5);
        repeat (50) @(posedge clk);
        check("idle", buf_valid, 1'b0);
        serve(0, 2, 1'b1, 1'b1, 16'h5, '{14'h0, `PRD_EVT_ENABLE, 1'b0, 15'h0}, 1);
        serve(2, 1, 1'b1, 1'b1, 16'h6, '{14'h0, `PRD_EVT_DISABLE, 1'b0, 15'h0}, 0);
        serve(3, 1, 1'b1, 1'b0, 16'h7, '{14'h0, `PRD_EVT_DESC, 1'b1, 15'h3}, 1);
        serve(0, 1, 1'b0, 1'b1, 16'h8, '{14'h0, 2'h3, 1'b0, 15'h0}, 0);
        serve(1, 2, 1'b0, 1'b1, 16'h9, '{14'h0, `PRD_EVT_DESC, 1'b1, 15'h1}, 0);
        rd(`PRD_REG_STATUS, d);
        check("status", d, 32'h0003_0003);
        wr(`PRD_REG_CTRL, 32'h7);
        batch2(16'hA, 16'hB);
        rd(`PRD_REG_STATUS, d);
        check("status", d, 32'h8001_8001);
        rd(`PRD_REG_ERR, d);
        check("err", d, 32'h0);
        wrap_up;
    end
    initial begin
        #200000;
        fail_count++;
        wrap_up;
    end
endmodule : tb_packed_ring_descriptor_engine
`default_nettype wire
